// file: inc/scp_pkg.sv
// Shared constants for the serial control port: device map and host map.
// Assumes one 10 MHz system clock on both ends.
package scp_pkg;
  // Instruction word layout
  localparam int INSTR_W = 16;
  localparam int RW_BIT = 15;
  localparam int LEN_HI = 14;
  localparam int LEN_LO = 13;
  localparam logic [1:0] LEN_STREAM = 2'h3;
  localparam logic [3:0] INSTR_LAST = 4'hf;
  localparam logic [3:0] BYTE_LAST = 4'h7;
  ////////////////////////////////////////////////////////////////////////////
  // Device register map
  localparam logic [12:0] ADDR_CFG = 13'h0000;
  localparam logic [12:0] ADDR_RBK = 13'h0004;
  localparam logic [12:0] ADDR_UPD = 13'h0232;
  localparam logic [12:0] ADDR_TOP = 13'h0b03;
  localparam logic [12:0] USER_BASE = 13'h0010;
  localparam logic [12:0] USER_END = 13'h0013;
  localparam int USER_N = 4;
  localparam int USER_IW = 2;
  localparam logic [7:0] CFG_RST = 8'h18;
  localparam logic [7:0] RBK_RST = 8'h00;
  localparam logic [7:0] USER_RST = 8'h00;
  localparam int CFG_UNI_HI = 7;
  localparam int CFG_UNI_LO = 0;
  localparam int CFG_LSB_HI = 6;
  localparam int CFG_LSB_LO = 1;
  localparam int RBK_SRC = 0;
  localparam int UPD_BIT = 0;
  ////////////////////////////////////////////////////////////////////////////
  // Timing
  localparam int CLK_NS = 100;
  localparam int SCLK_NS = 800;
  localparam int HALF_CYC = SCLK_NS / (2 * CLK_NS);
  localparam logic [2:0] HALF_LAST = 3'(HALF_CYC - 1);
  localparam logic [1:0] GAP_HALVES = 2'h2;
  ////////////////////////////////////////////////////////////////////////////
  // Host register map (APB byte offsets)
  localparam logic [7:0] HREG_CTRL = 8'h00;
  localparam logic [7:0] HREG_TX = 8'h04;
  localparam logic [7:0] HREG_RX = 8'h08;
  localparam logic [7:0] HREG_STAT = 8'h0c;
  localparam logic [7:0] HREG_CFG = 8'h10;
  localparam int CFG_H_LSB = 0;
  localparam int CFG_H_UNI = 1;
  localparam int CFG_H_STALL = 2;
  localparam int CTRL_SCNT_LO = 16;
  localparam int STAT_BUSY = 0;
  localparam int STAT_DONE = 1;
  localparam logic [5:0] INSTR_BITS = 6'h10;
endpackage

// file: inc/scp_if.sv
// Serial link between host end and device end.
// Resolves the shared data pin and readback pin from the enables; undriven reads 0.
`timescale 1ns/1ns
interface scp_if;
  logic sclk;
  logic cs_n;
  logic data_h;
  logic data_h_oe;
  logic data_d;
  logic data_d_oe;
  logic rb_d;
  logic rb_d_oe;
  logic data_pin;
  logic separate_readback_pin;
  // Wire levels from whoever drives
  assign data_pin = data_d_oe ? data_d : (data_h_oe ? data_h : 1'b0);
  assign separate_readback_pin = rb_d_oe ? rb_d : 1'b0;
  modport dev (input sclk, cs_n, data_pin, output data_d, data_d_oe, rb_d, rb_d_oe);
  modport host (output sclk, cs_n, data_h, data_h_oe, input data_pin, separate_readback_pin);
endinterface

// file: rtl/scp_dev.sv
// Device end of the serial control port with its register set.
// Assumes pclk much faster than sclk; link pins are asynchronous.
//
// How it works
// - capture on sclk rise, shift out on fall
// - reset to bidirectional, direction bit zero
// - both outputs released while chip select high
// - chip select fall starts a new cycle unless one is stalled
// - every instruction is sixteen bits long
// - read flag, length code, 13-bit address
// - length code gives 1, 2, 3 or streaming
// - byte-boundary chip select high stalls, resumes
// - short mid-byte low pulse aborts stalled transfer
// - non-boundary chip select rise resets, flushes
// - host ends streaming by raising chip select
// - writes buffered except config; update bit copies, self-clears
// - read shifts N bytes or streams
// - stepping moves by one, except MSB-first wraps 0 to 0x232
// - both direction bits set use readback pin
// - readback control bit picks buffer or active
// - decode addresses zero through 0xB03
// - host mirrors nibbles of config writes
// - bit order change applies at once
// - MSB first order decrements address
// - LSB first order increments address
// - streaming stops at update register address
`timescale 1ns/1ns
module scp_dev
  import scp_pkg::*;
(
  // System
  input wire logic pclk,
  input wire logic presetn,
  // Link
  scp_if.dev link,
  // User side
  output logic [7:0] cfg_active,
  output logic [USER_N-1:0][7:0] user_active,
  output logic update_strobe,
  output logic busy
);
  typedef enum logic [1:0] {DS_IDLE, DS_INSTR, DS_DATA, DS_DONE} scp_dst_t;

  typedef struct packed {
    logic cs_a;                      // Synchroniser stages
    logic cs_b;
    logic cs_d;                      // Previous synced level
    logic ck_a;
    logic ck_b;
    logic ck_d;
    logic di_a;
    logic di_b;
    scp_dst_t st;                    // Protocol phase
    logic [3:0] cnt;                 // Bits taken in word or byte
    logic [15:0] sh;                 // Receive shifter
    logic rw;                        // Read flag
    logic [1:0] len;                 // transfer_length_code
    logic [1:0] left;                // Bytes left minus one
    logic [12:0] addr;               // Current register address
    logic [7:0] txb;                 // Byte being read out
    logic obit;                      // Readback bit on the pins
    logic [7:0] cfg;                 // Port config, live
    logic [7:0] rbk_buf;             // Readback control buffer
    logic [7:0] rbk_act;             // Readback control active
    logic [USER_N-1:0][7:0] ubuf;    // User bytes, buffer
    logic [USER_N-1:0][7:0] uact;    // User bytes, active
    logic upd;                       // Update pulse
  } scp_dev_state_t;

  scp_dev_state_t s;
  scp_dev_state_t next_s;
  logic cs_rise;
  logic cs_fall;
  logic ck_rise;
  logic ck_fall;
  logic lsb;
  logic uni;
  logic last;
  logic [15:0] ins;
  logic [7:0] wbyte;
  logic [12:0] step;

  ////////////////////////////////////////////////////////////////////////////
  // Readback byte for an address; unknown addresses read zero
  function automatic logic [7:0] rd_byte(input scp_dev_state_t q, input logic [12:0] a);
    logic act;
    logic [12:0] off;
    act = q.rbk_act[RBK_SRC];
    off = a - USER_BASE;
    rd_byte = 8'h00;
    if (a > ADDR_TOP) begin
      rd_byte = 8'h00;
    end else if (a == ADDR_CFG) begin
      rd_byte = q.cfg;
    end else if (a == ADDR_RBK) begin
      rd_byte = act ? q.rbk_act : q.rbk_buf;
    end else if (a >= USER_BASE && a <= USER_END) begin
      rd_byte = act ? q.uact[off[USER_IW-1:0]] : q.ubuf[off[USER_IW-1:0]];
    end
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Next state
  always_comb begin
    next_s = s;
    next_s.upd = 1'b0;
    // Two flops on every link input before use
    next_s.cs_a = link.cs_n;
    next_s.cs_b = s.cs_a;
    next_s.cs_d = s.cs_b;
    next_s.ck_a = link.sclk;
    next_s.ck_b = s.ck_a;
    next_s.ck_d = s.ck_b;
    next_s.di_a = link.data_pin;
    next_s.di_b = s.di_a;
    cs_rise = s.cs_b & ~s.cs_d;
    cs_fall = ~s.cs_b & s.cs_d;
    ck_rise = s.ck_b & ~s.ck_d & ~s.cs_b;
    ck_fall = ~s.ck_b & s.ck_d & ~s.cs_b;
    // Bit order straight from live config
    lsb = s.cfg[CFG_LSB_LO] & s.cfg[CFG_LSB_HI];
    uni = s.cfg[CFG_UNI_HI] & s.cfg[CFG_UNI_LO];
    ins = lsb ? {s.di_b, s.sh[15:1]} : {s.sh[14:0], s.di_b};
    wbyte = lsb ? ins[15:8] : ins[7:0];
    // Address stepping; MSB-first wraps from zero to the update register
    if (lsb) begin
      step = s.addr + 13'h0001;
    end else if (s.addr == ADDR_CFG) begin
      step = ADDR_UPD;
    end else begin
      step = s.addr - 13'h0001;
    end
    if (s.len == LEN_STREAM) begin
      last = (s.addr == ADDR_UPD);
    end else begin
      last = (s.left == 2'h0);
    end
    if (cs_rise) begin
      // Chip select rise: stall, finish or flush
      case (s.st)
        DS_INSTR: begin
          if (s.cnt[2:0] != 3'h0) begin
            next_s.st = DS_IDLE;
            next_s.cnt = 4'h0;
          end
        end
        DS_DATA: begin
          if (s.cnt[2:0] != 3'h0 || s.len == LEN_STREAM) begin
            next_s.st = DS_IDLE;
            next_s.cnt = 4'h0;
          end
        end
        DS_DONE: begin
          next_s.st = DS_IDLE;
        end
        default: begin
          next_s.st = DS_IDLE;
        end
      endcase
    end else if (cs_fall) begin
      // New cycle unless a stalled one resumes
      if (s.st == DS_IDLE || s.st == DS_DONE) begin
        next_s.st = DS_INSTR;
        next_s.cnt = 4'h0;
      end
    end else if (ck_rise && s.st == DS_INSTR) begin
      // Sixteen-bit instruction word
      next_s.sh = ins;
      next_s.cnt = s.cnt + 4'h1;
      if (s.cnt == INSTR_LAST) begin
        next_s.rw = ins[RW_BIT];
        next_s.len = ins[LEN_HI:LEN_LO];
        next_s.left = ins[LEN_HI:LEN_LO];
        next_s.addr = ins[12:0];
        next_s.txb = rd_byte(s, ins[12:0]);
        next_s.cnt = 4'h0;
        next_s.st = DS_DATA;
      end
    end else if (ck_rise && s.st == DS_DATA) begin
      // Data bytes
      next_s.sh = ins;
      next_s.cnt = s.cnt + 4'h1;
      if (s.cnt == BYTE_LAST) begin
        next_s.cnt = 4'h0;
        if (!s.rw) begin
          if (s.addr == ADDR_CFG) begin
            next_s.cfg = wbyte;
          end else if (s.addr == ADDR_RBK) begin
            next_s.rbk_buf = wbyte;
          end else if (s.addr == ADDR_UPD) begin
            if (wbyte[UPD_BIT]) begin
              next_s.rbk_act = s.rbk_buf;
              next_s.uact = s.ubuf;
              next_s.upd = 1'b1;
            end
          end else if (s.addr >= USER_BASE && s.addr <= USER_END) begin
            next_s.ubuf[USER_IW'(s.addr - USER_BASE)] = wbyte;
          end
        end
        if (last) begin
          next_s.st = DS_DONE;
        end else begin
          next_s.left = s.left - 2'h1;
          next_s.addr = step;
          next_s.txb = rd_byte(s, step);
        end
      end
    end else if (ck_fall && s.st == DS_DATA && s.rw) begin
      // Readback bit changes on the falling edge
      next_s.obit = lsb ? s.txb[s.cnt[2:0]] : s.txb[3'h7 - s.cnt[2:0]];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // State register
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s <= '0;
      s.cs_a <= 1'b1;
      s.cs_b <= 1'b1;
      s.cs_d <= 1'b1;
      s.st <= DS_IDLE;
      s.cfg <= CFG_RST;
      s.rbk_buf <= RBK_RST;
      s.rbk_act <= RBK_RST;
      s.ubuf <= {USER_N{USER_RST}};
      s.uact <= {USER_N{USER_RST}};
    end else begin
      s <= next_s;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Pins: drive only during readback with chip select low
  always_comb begin
    link.data_d = s.obit;
    link.rb_d = s.obit;
    link.data_d_oe = ~s.cs_b & (s.st == DS_DATA) & s.rw & ~uni;
    link.rb_d_oe = ~s.cs_b & (s.st == DS_DATA) & s.rw & uni;
  end

  assign cfg_active = s.cfg;
  assign user_active = s.uact;
  assign update_strobe = s.upd;
  assign busy = (s.st == DS_INSTR) | (s.st == DS_DATA);
endmodule

// file: rtl/scp_host.sv
// Host end: APB-programmed master that drives the serial control port.
// Assumes the device end on the other side of scp_if; sclk made here.
`timescale 1ns/1ns
module scp_host
  import scp_pkg::*;
(
  // System
  input wire logic pclk,
  input wire logic presetn,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Link
  scp_if.host link
);
  typedef enum logic [2:0] {HS_IDLE, HS_SETUP, HS_LOW, HS_HIGH, HS_GAP} scp_hst_t;

  typedef struct packed {
    logic [1:0] din_a;    // Readback synchroniser, separate pin on top
    logic [1:0] din_b;
    scp_hst_t st;         // Transfer phase
    logic [2:0] div;      // Half-period divider
    logic [1:0] gap;      // Stall halves left
    logic [15:0] ins;     // Instruction word
    logic [31:0] tx;      // Bytes to send, byte 0 first
    logic [31:0] rx;      // Bytes received
    logic [5:0] idx;      // Current bit
    logic [5:0] total;    // Bits in the cycle
    logic [2:0] cfg;      // Order, readback pin, stall
    logic [1:0] scnt;     // Streaming bytes minus one
    logic done;           // Cycle finished
    logic sclk;
    logic cs_n;
    logic dout;
    logic oe;
    logic [31:0] rdata;   // APB read data
  } scp_host_state_t;

  scp_host_state_t s;
  scp_host_state_t next_s;
  logic tick;
  logic wr;
  logic [1:0] nb;
  logic [5:0] nx;
  logic [5:0] ri;         // Receive slot in rx
  logic din;              // Synced readback bit from the selected pin

  ////////////////////////////////////////////////////////////////////////////
  // Bit to send at a given index, honouring bit order
  function automatic logic bit_at(input scp_host_state_t q, input logic [5:0] i);
    logic [5:0] d;
    logic [7:0] b;
    d = i - INSTR_BITS;
    b = q.tx[{d[4:3], 3'h0} +: 8];
    if (i < INSTR_BITS) begin
      bit_at = q.cfg[CFG_H_LSB] ? q.ins[i[3:0]] : q.ins[4'hf - i[3:0]];
    end else begin
      bit_at = q.cfg[CFG_H_LSB] ? b[d[2:0]] : b[3'h7 - d[2:0]];
    end
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Next state
  always_comb begin
    next_s = s;
    // Both pins pass two flops before the pin select, so the mux never sees a raw pin
    next_s.din_a = {link.separate_readback_pin, link.data_pin};
    next_s.din_b = s.din_a;
    din = s.cfg[CFG_H_UNI] ? s.din_b[1] : s.din_b[0];
    tick = (s.div == HALF_LAST);
    next_s.div = (s.st == HS_IDLE || tick) ? 3'h0 : s.div + 3'h1;
    wr = psel & penable & pwrite;
    nx = s.idx + 6'h1;
    // Receive slot; MSB first lands the first bit at the top of its byte
    ri = s.idx - INSTR_BITS;
    if (!s.cfg[CFG_H_LSB]) begin
      ri[2:0] = 3'h7 - ri[2:0];
    end
    nb = (pwdata[LEN_HI:LEN_LO] == LEN_STREAM) ? pwdata[CTRL_SCNT_LO +: 2] :
         pwdata[LEN_HI:LEN_LO];
    // APB register writes; start only when idle
    if (wr && paddr == HREG_TX) begin
      next_s.tx = pwdata;
    end
    if (wr && paddr == HREG_CFG) begin
      next_s.cfg = pwdata[2:0];
    end
    if (wr && paddr == HREG_CTRL && s.st == HS_IDLE) begin
      next_s.ins = pwdata[15:0];
      next_s.scnt = pwdata[CTRL_SCNT_LO +: 2];
      next_s.total = INSTR_BITS + {1'b0, nb, 3'h0} + 6'h8;
      next_s.idx = 6'h0;
      next_s.done = 1'b0;
      next_s.rx = 32'h0000_0000;
      next_s.st = HS_SETUP;
      next_s.cs_n = 1'b0;
      if (pwdata[12:0] == ADDR_CFG && !pwdata[RW_BIT]) begin
        // Mirror nibbles so either bit order reads the same
        next_s.tx[7:4] = {s.tx[0], s.tx[1], s.tx[2], s.tx[3]};
        if (wr && paddr == HREG_TX) begin
          next_s.tx[7:4] = {pwdata[0], pwdata[1], pwdata[2], pwdata[3]};
        end
      end
    end
    // Serial sequencer, one step per half period
    case (s.st)
      HS_SETUP: begin
        next_s.dout = bit_at(s, s.idx);
        next_s.oe = 1'b1;
        if (tick) begin
          next_s.st = HS_HIGH;
          next_s.sclk = 1'b1;
        end
      end
      HS_LOW: begin
        if (tick) begin
          next_s.st = HS_HIGH;
          next_s.sclk = 1'b1;
        end
      end
      HS_HIGH: begin
        if (tick) begin
          next_s.sclk = 1'b0;
          next_s.idx = nx;
          if (s.ins[RW_BIT] && s.idx >= INSTR_BITS) begin
            next_s.rx[ri[4:0]] = din;
          end
          if (nx == s.total) begin
            next_s.st = HS_IDLE;
            next_s.cs_n = 1'b1;
            next_s.oe = 1'b0;
            next_s.done = 1'b1;
          end else if (s.cfg[CFG_H_STALL] && nx[2:0] == 3'h0 &&
                       s.ins[LEN_HI:LEN_LO] != LEN_STREAM) begin
            next_s.st = HS_GAP;
            next_s.cs_n = 1'b1;
            next_s.oe = 1'b0;
            next_s.gap = GAP_HALVES;
          end else begin
            next_s.st = HS_LOW;
            next_s.dout = bit_at(s, nx);
            next_s.oe = (nx < INSTR_BITS) | ~s.ins[RW_BIT];
          end
        end
      end
      HS_GAP: begin
        if (tick) begin
          next_s.gap = s.gap - 2'h1;
          if (s.gap == 2'h1) begin
            next_s.st = HS_SETUP;
            next_s.cs_n = 1'b0;
          end
        end
      end
      default: begin
        next_s.sclk = 1'b0;
        next_s.oe = 1'b0;
      end
    endcase
    if (s.st == HS_SETUP) begin
      next_s.oe = (s.idx < INSTR_BITS) | ~s.ins[RW_BIT];
    end
    // Read data captured in setup, shown in access
    if (psel && !penable) begin
      case (paddr)
        HREG_CTRL: next_s.rdata = {14'h0000, s.scnt, s.ins};
        HREG_TX: next_s.rdata = s.tx;
        HREG_RX: next_s.rdata = s.rx;
        HREG_STAT: next_s.rdata = {30'h0000_0000, s.done, s.st != HS_IDLE};
        HREG_CFG: next_s.rdata = {29'h0000_0000, s.cfg};
        default: next_s.rdata = 32'h0000_0000;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // State register
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s <= '0;
      s.st <= HS_IDLE;
      s.cs_n <= 1'b1;
    end else begin
      s <= next_s;
    end
  end

  assign link.sclk = s.sclk;
  assign link.cs_n = s.cs_n;
  assign link.data_h = s.dout;
  assign link.data_h_oe = s.oe & ~s.cs_n;
  assign prdata = s.rdata;
  assign pready = 1'b1;
  assign pslverr = 1'b0;
endmodule

// file: verif/scp_link_assertions.sv
// Checker for the serial link between host end and device end.
// Assumes link signals are pclk-synchronous and no frame is aborted.
`timescale 1ns/1ns
module scp_link_assertions (
  // System
  input wire logic pclk,
  input wire logic presetn,
  // Link
  input wire logic sclk,
  input wire logic cs_n,
  input wire logic data_h,
  input wire logic data_h_oe,
  input wire logic data_d,
  input wire logic data_d_oe,
  input wire logic rb_d,
  input wire logic rb_d_oe
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  logic [2:0] rises; // Serial clock rises modulo one byte
  logic sclk_q; // Last serial clock level
  ////////////////////////////////////////////////////////////////////////////
  // Bit counter; only wraps on whole bytes in a legal frame
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rises <= 3'h0;
      sclk_q <= 1'b0;
    end else begin
      sclk_q <= sclk;
      if (sclk && !sclk_q) begin
        rises <= rises + 3'h1;
      end
    end
  end
  ////////////////////////////////////////////////////////////////////////////
  sequence s_high4;
    sclk [*4];
  endsequence
  property p_half;
    $rose(sclk) |-> s_high4 ##1 !sclk;
  endproperty
  a_half: assert property (p_half) else $error("sclk high time wrong");
  property p_idle;
    cs_n |-> !sclk;
  endproperty
  a_idle: assert property (p_idle) else $error("sclk moves while deselected");
  property p_release;
    cs_n [*5] |-> !data_d_oe && !rb_d_oe;
  endproperty
  a_release: assert property (p_release) else $error("pins driven while deselected");
  property p_one_pin;
    !(data_d_oe && rb_d_oe);
  endproperty
  a_one_pin: assert property (p_one_pin) else $error("both readback pins driven");
  property p_stable_h;
    sclk && $past(sclk) && data_h_oe |-> $stable(data_h);
  endproperty
  a_stable_h: assert property (p_stable_h) else $error("host data moved in sclk high");
  property p_stable_d;
    sclk && $past(sclk) && $past(sclk, 2) && $past(data_d_oe) |-> $stable(data_d);
  endproperty
  a_stable_d: assert property (p_stable_d) else $error("readback moved in sclk high");
  property p_stable_rb;
    sclk && $past(sclk) && $past(sclk, 2) && $past(rb_d_oe) |-> $stable(rb_d);
  endproperty
  a_stable_rb: assert property (p_stable_rb) else $error("rb pin moved in sclk high");
  property p_boundary;
    $rose(cs_n) |-> rises == 3'h0;
  endproperty
  a_boundary: assert property (p_boundary) else $error("frame ends off a byte");
  property p_oe_start;
    $rose(data_d_oe || rb_d_oe) |-> !cs_n && rises == 3'h0;
  endproperty
  a_oe_start: assert property (p_oe_start) else $error("readback starts off a byte");
endmodule

// file: verif/test_spi_serial_control_port.sv
// Bench: drives the host end over APB, watches device outputs.
// Assumes the host end clocks the link from pclk.
`timescale 1ns/1ns
module test_spi_serial_control_port;
  import scp_pkg::*;
  typedef struct {logic [31:0] v; logic [31:0] m;} scp_exp_t;
  // Bus and device side
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, update_strobe;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, got, w, s;
  logic [USER_N-1:0][7:0] user_active;
  logic got_v, bz, dev_busy;
  logic [7:0] cfg_act;
  logic [7:0] ub [4]; // Model of buffered user bytes
  scp_exp_t exp_rd [$]; // Notes for reads
  logic [31:0] exp_act [$]; // Notes for updates
  scp_exp_t e;
  int error_cnt, checks;
  scp_if scp_if_i ();
  scp_host scp_host_i (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .link(scp_if_i));
  scp_dev scp_dev_i (.pclk(pclk), .presetn(presetn), .link(scp_if_i), .cfg_active(cfg_act),
    .user_active(user_active), .update_strobe(update_strobe), .busy(dev_busy));
  scp_link_assertions scp_link_assertions_i (.pclk(pclk), .presetn(presetn),
    .sclk(scp_if_i.sclk), .cs_n(scp_if_i.cs_n), .data_h(scp_if_i.data_h),
    .data_h_oe(scp_if_i.data_h_oe), .data_d(scp_if_i.data_d),
    .data_d_oe(scp_if_i.data_d_oe), .rb_d(scp_if_i.rb_d), .rb_d_oe(scp_if_i.rb_d_oe));
  ////////////////////////////////////////////////////////////////////////////
  initial begin
    pclk = 1'b0;
    forever #50 pclk = ~pclk;
  end
  function automatic logic [15:0] ins(logic r, logic [1:0] l, logic [12:0] a);
    return {r, l, a};
  endfunction
  // One APB transfer; waits on pready, no fixed latency assumed
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d,
    output logic [31:0] q);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    q = prdata;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask
  // Hand a read result to the watcher
  task automatic post(input logic [31:0] q);
    got <= q;
    got_v <= 1'b1;
    @(posedge pclk);
    got_v <= 1'b0;
    @(posedge pclk);
  endtask
  // Full link cycle: program, start, poll done, fetch received bytes
  task automatic xfer(input logic [2:0] hc, input logic [15:0] i, input logic [1:0] sc,
    input logic [31:0] tx, output logic [31:0] rx);
    int n;
    apb(1'b1, HREG_TX, tx, s);
    apb(1'b1, HREG_CFG, {29'h0, hc}, s);
    apb(1'b1, HREG_CTRL, {14'h0, sc, i}, s);
    n = 0;
    s = 32'h0;
    bz = 1'b0;
    while (s[STAT_DONE] !== 1'b1 && n < 400) begin
      apb(1'b0, HREG_STAT, 32'h0, s);
      bz = bz | dev_busy;
      n++;
    end
    if (n >= 400) begin
      error_cnt++;
      $display("[ERR] %0t link cycle never finished", $time);
    end
    apb(1'b0, HREG_RX, 32'h0, rx);
  endtask
  task automatic wr(input logic [2:0] hc, input logic [15:0] i, input logic [31:0] tx);
    xfer(hc, i, 2'h3, tx, s);
    exp_rd.push_back('{32'h1, 32'h1});
    post({31'h0, bz});
  endtask
  task automatic rd(input logic [2:0] hc, input logic [15:0] i, input logic [1:0] sc,
    input logic [31:0] v, input logic [31:0] m);
    logic [31:0] q;
    exp_rd.push_back('{v, m});
    xfer(hc, i, sc, 32'h0, q);
    post(q);
  endtask
  // Update: the whole buffer goes live at once
  task automatic upd();
    exp_act.push_back({ub[3], ub[2], ub[1], ub[0]});
    wr(3'h0, ins(1'b0, 2'h0, ADDR_UPD), 32'h1);
  endtask
  task automatic give_verdict();
    $display("checks=%0d error_cnt=%0d", checks, error_cnt);
    if (error_cnt == 0 && checks > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////////////////
  // Watcher: oldest note against each result as it shows up
  always @(posedge pclk) begin
    if (got_v === 1'b1) begin
      e = exp_rd.pop_front();
      checks++;
      if ((got & e.m) !== e.v) begin
        error_cnt++;
        $display("[ERR] %0t read %h expected %h", $time, got & e.m, e.v);
      end
    end
    // Every access completes without a slave error
    if (psel === 1'b1 && penable === 1'b1 && pready === 1'b1) begin
      checks++;
      if (pslverr !== 1'b0) begin
        error_cnt++;
        $display("[ERR] %0t slave error on access", $time);
      end
    end
    if (update_strobe === 1'b1) begin
      checks++;
      if (exp_act.size() == 0 || user_active !== exp_act.pop_front()) begin
        error_cnt++;
        $display("[ERR] %0t active bytes %h wrong", $time, user_active);
      end
    end
  end
  // Watchdog against a hung link
  initial begin
    repeat (60000) @(posedge pclk);
    error_cnt++;
    $display("[ERR] %0t watchdog expired", $time);
    give_verdict();
  end
  ////////////////////////////////////////////////////////////////////////////
  initial begin
    void'($urandom(41279));
    {psel, penable, pwrite, got_v, paddr, pwdata, got} = '0;
    error_cnt = 0;
    checks = 0;
    ub = '{default: 8'h00};
    presetn = 1'b0;
    repeat (10) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    apb(1'b0, 8'h20, 32'h0, s);
    exp_rd.push_back('{32'h0, 32'hffff_ffff});
    post(s);
    rd(3'h0, ins(1'b1, 2'h0, ADDR_CFG), 2'h0, 32'h18, 32'hff);
    exp_rd.push_back('{{24'h0, CFG_RST}, 32'hff});
    post({24'h0, cfg_act});
    // Lengths one to three, MSB first, stalled writes then buffer reads
    for (int l = 0; l < 3; l++) begin
      w = $urandom();
      for (int k = 0; k <= l; k++) ub[3 - k] = w[8 * k +: 8];
      wr(3'h4, ins(1'b0, l[1:0], USER_END), w);
      rd(3'h0, ins(1'b1, l[1:0], USER_END), 2'h0, {8'h0, ub[1], ub[2], ub[3]} &
        ((32'h1 << (8 * (l + 1))) - 32'h1), (32'h1 << (8 * (l + 1))) - 32'h1);
    end
    upd();
    rd(3'h0, ins(1'b1, 2'h0, ADDR_UPD), 2'h0, 32'h0, 32'hff);
    // Active readback hides a newer buffered byte
    wr(3'h0, ins(1'b0, 2'h0, ADDR_RBK), 32'h1);
    upd();
    w = $urandom();
    wr(3'h0, ins(1'b0, 2'h0, USER_END), w);
    rd(3'h0, ins(1'b1, 2'h0, USER_END), 2'h0, {24'h0, ub[3]}, 32'hff);
    ub[3] = w[7:0];
    // LSB first: at once, incrementing, stream stops at update reg
    wr(3'h0, ins(1'b0, 2'h0, ADDR_CFG), 32'h5a);
    exp_rd.push_back('{32'h5a, 32'hff});
    post({24'h0, cfg_act});
    w = $urandom();
    ub[0] = w[7:0];
    ub[1] = w[15:8];
    wr(3'h1, ins(1'b0, 2'h1, USER_BASE), w);
    exp_act.push_back({ub[3], ub[2], ub[1], ub[0]});
    wr(3'h1, ins(1'b0, LEN_STREAM, 13'h0230), 32'hff01_0000);
    rd(3'h1, ins(1'b1, 2'h1, USER_BASE), 2'h0, {16'h0, ub[1], ub[0]}, 32'hffff);
    wr(3'h1, ins(1'b0, 2'h0, ADDR_CFG), 32'h18);
    // MSB stream wraps from 0x000 to 0x232 and stops
    rd(3'h0, ins(1'b1, LEN_STREAM, 13'h0001), 2'h3, 32'h0000_1800, 32'h00ff_ffff);
    // Unidirectional readback pin
    wr(3'h0, ins(1'b0, 2'h0, ADDR_CFG), 32'h99);
    rd(3'h2, ins(1'b1, 2'h0, ADDR_CFG), 2'h0, 32'h99, 32'hff);
    wr(3'h0, ins(1'b0, 2'h0, ADDR_CFG), 32'h18);
    wr(3'h0, ins(1'b0, 2'h0, 13'h0c00), 32'hab);
    rd(3'h0, ins(1'b1, 2'h0, 13'h0c00), 2'h0, 32'h0, 32'hff);
    repeat (4) @(posedge pclk);
    give_verdict();
  end
endmodule
